// file: rtl/aps_pkg.sv
// Constants shared by the ADC peak and serial clocking block
package aps_pkg;
  localparam int SAMPLE_W      = 24;
  localparam int PEAK_W        = 6;
  localparam int NUM_CHANNELS  = 2;
  localparam int MAX_RATE_KHZ  = 96;
  localparam int CNT_W         = 9;
  // Frame lengths in internal clock cycles
  localparam int FRAME_SLOW    = 512;
  localparam int FRAME_FAST    = 256;
  // Decimation ratios per rate class
  localparam logic [7:0] OSR_SLOW = 8'h80;
  localparam logic [7:0] OSR_FAST = 8'h40;
  // Peak code limits and dB per bit of magnitude
  localparam logic [PEAK_W-1:0] PEAK_FLOOR = 6'h3F;
  localparam int DB_PER_BIT   = 6;
  localparam int MSB_POS      = 23;
  // Word width selector codes
  localparam logic [1:0] WIDTH_16 = 2'h0;
  localparam logic [1:0] WIDTH_20 = 2'h1;
  localparam logic [23:0] MASK_16 = 24'hFFFF00;
  localparam logic [23:0] MASK_20 = 24'hFFFFF0;
  localparam logic [23:0] MASK_24 = 24'hFFFFFF;
  // Reset values
  localparam logic [CNT_W-1:0] CNT_RST = 9'h000;
  localparam int BUF_DEPTH    = 2;
endpackage

// file: rtl/aps_peak_detect.sv
// Per-channel peak detector with clear-on-read
`timescale 1ns/1ns
module aps_peak_detect
  import aps_pkg::*;
#(
  parameter int W = SAMPLE_W
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic [W-1:0]      sample,
  input  wire logic              sample_valid,
  input  wire logic              peak_read,
  output logic      [PEAK_W-1:0] peak
);
  // ***************************************************
  // Magnitude and running maximum
  // ***************************************************
  logic [W-1:0] max_reg;
  logic [W-1:0] max_next;
  logic [W-1:0] mag;
  logic [W-1:0] base;
  logic         bigger;

  assign mag    = sample[W-1] ? W'(~sample + 1'b1) : sample;
  assign bigger = sample_valid && (mag > base);
  // Read clears, but a sample arriving with the read still counts
  assign base     = peak_read ? '0 : max_reg;
  assign max_next = bigger ? mag : base;

  // ***************************************************
  // Conversion to whole dB below full scale
  // ***************************************************
  logic [4:0] lead;
  logic [W-1:0] norm;
  logic [2:0] frac;
  logic [2:0] frac_db;
  logic [7:0] coarse;
  logic [7:0] code_wide;
  logic [PEAK_W-1:0] code;

  always_comb begin
    lead = 5'(MSB_POS);
    for (int i = 0; i <= MSB_POS; i++) begin
      if (max_next[i]) begin
        lead = 5'(MSB_POS - i);
      end
    end
  end

  assign norm    = max_next << lead;
  assign frac    = norm[W-2 -: 3];
  assign frac_db = (frac == 3'h0) ? 3'h0 :
                   (frac == 3'h1) ? 3'h1 :
                   (frac == 3'h2) ? 3'h2 :
                   (frac == 3'h3) ? 3'h3 :
                   (frac <= 3'h5) ? 3'h4 : 3'h5;
  assign coarse    = 8'(DB_PER_BIT) * {3'h0, lead};
  assign code_wide = (coarse > {5'h00, frac_db}) ?
                     8'(coarse - {5'h00, frac_db}) : 8'h00;
  // 1 dB steps, saturating at the floor code 63 (PEAK_FLOOR)
  assign code = (max_next == '0 || code_wide > 8'(PEAK_FLOOR)) ?
                PEAK_FLOOR : code_wide[PEAK_W-1:0];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      max_reg <= '0;
      peak    <= PEAK_FLOOR;
    end else begin
      max_reg <= max_next;
      peak    <= code;
    end
  end
endmodule

// file: rtl/aps_adc_port.sv
// Stereo ADC digital side: clocking, serial output, peak levels
//
// Behaviour
// - Two ADC channels form one stereo pair, rates up to 96 kHz.
// - Decimation ratio is 128 in the 48 kHz class, 64 in 96 kHz.
// - Each channel reports its peak as a 6-bit code, 0 to -63 dB.
// - Peak value holds until read; the read clears it for new capture.
// - Both channels share one bit clock and one frame clock.
// - Strap high makes clock pins inputs, strap low makes them outputs.
// - With output pins the block generates bit and frame clocks itself.
// - I2S default: word starts one bit clock after the frame edge.
// - Samples are two's complement, 16, 20 or 24 bits wide.
// - Sample rate is internal clock /512, or /256 when selected.
// - Peak reads arrive as one read strobe input per channel.
`timescale 1ns/1ns
module aps_adc_port
  import aps_pkg::*;
#(
  parameter int W = SAMPLE_W
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              ms_strap_pin,
  input  wire logic              adc_bit_clock_in,
  input  wire logic              adc_frame_clock_in,
  input  wire logic              rate_fast_sel,
  input  wire logic [1:0]        word_width_sel,
  input  wire logic [W-1:0]      sample_left,
  input  wire logic [W-1:0]      sample_right,
  input  wire logic              sample_valid,
  output logic                   sample_ready,
  input  wire logic              peak_read_left,
  input  wire logic              peak_read_right,
  output logic      [PEAK_W-1:0] peak_left,
  output logic      [PEAK_W-1:0] peak_right,
  output logic                   adc_bit_clock_out,
  output logic                   adc_bit_clock_oe,
  output logic                   adc_frame_clock_out,
  output logic                   adc_frame_clock_oe,
  output logic                   adc_serial_out,
  output logic      [7:0]        decim_ratio,
  output logic                   master_mode
);
  // ***************************************************
  // Pin synchronisers
  // ***************************************************
  logic [1:0] strap_sync_reg;
  logic [1:0] bclk_sync_reg;
  logic [1:0] fclk_sync_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      // Pins stay inputs until the strap is known
      strap_sync_reg <= 2'h3;
      bclk_sync_reg  <= 2'h0;
      fclk_sync_reg  <= 2'h0;
    end else begin
      strap_sync_reg <= {strap_sync_reg[0], ms_strap_pin};
      bclk_sync_reg  <= {bclk_sync_reg[0], adc_bit_clock_in};
      fclk_sync_reg  <= {fclk_sync_reg[0], adc_frame_clock_in};
    end
  end

  // ***************************************************
  // Mode and rate
  // ***************************************************
  logic       master_next;
  logic [7:0] decim_next;

  assign master_next = ~strap_sync_reg[1];
  assign decim_next  = rate_fast_sel ? OSR_FAST : OSR_SLOW;

  // ***************************************************
  // Internal clock generation
  // ***************************************************
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             gen_bclk;
  logic             gen_fclk;

  // Frame of 512 or 256 internal clocks, 64 bit clocks each
  assign cnt_next = rate_fast_sel ?
                    {1'b0, 8'(cnt_reg[7:0] + 8'h01)} :
                    9'(cnt_reg + 9'h001);
  assign gen_bclk = rate_fast_sel ? cnt_reg[1] : cnt_reg[2];
  assign gen_fclk = rate_fast_sel ? cnt_reg[7] : cnt_reg[8];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_reg             <= CNT_RST;
      master_mode         <= 1'b0;
      decim_ratio         <= OSR_SLOW;
      adc_bit_clock_out   <= 1'b0;
      adc_frame_clock_out <= 1'b0;
      adc_bit_clock_oe    <= 1'b0;
      adc_frame_clock_oe  <= 1'b0;
    end else begin
      cnt_reg             <= cnt_next;
      master_mode         <= master_next;
      decim_ratio         <= decim_next;
      adc_bit_clock_out   <= master_next & gen_bclk;
      adc_frame_clock_out <= master_next & gen_fclk;
      adc_bit_clock_oe    <= master_next;
      adc_frame_clock_oe  <= master_next;
    end
  end

  // ***************************************************
  // Shared clock edge detection
  // ***************************************************
  logic src_bclk;
  logic src_fclk;
  logic bclk_prev_reg;
  logic fclk_last_reg;
  logic bclk_fall;
  logic frame_edge;

  // Slave mode follows the controller's clocks
  assign src_bclk  = master_mode ? adc_bit_clock_out : bclk_sync_reg[1];
  assign src_fclk  = master_mode ? adc_frame_clock_out :
                     fclk_sync_reg[1];
  assign bclk_fall = bclk_prev_reg & ~src_bclk;
  assign frame_edge = bclk_fall && (src_fclk != fclk_last_reg);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bclk_prev_reg <= 1'b0;
      fclk_last_reg <= 1'b0;
    end else begin
      bclk_prev_reg <= src_bclk;
      if (bclk_fall) begin
        fclk_last_reg <= src_fclk;
      end
    end
  end

  // ***************************************************
  // Two-entry sample buffer
  // ***************************************************
  logic [2*W-1:0] buf_mem [BUF_DEPTH];
  logic           wr_ptr_reg;
  logic           rd_ptr_reg;
  logic [1:0]     count_reg;
  logic [1:0]     count_next;
  logic           push;
  logic           pop;
  logic           buf_valid;
  logic [2*W-1:0] buf_head;

  assign buf_valid  = (count_reg != 2'h0);
  assign buf_head   = buf_mem[rd_ptr_reg];
  assign push       = sample_valid && sample_ready;
  // Left slot start of each frame drains one stereo pair
  assign pop        = frame_edge && !src_fclk && buf_valid;
  assign count_next = 2'(count_reg + {1'b0, push} - {1'b0, pop});

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr_reg   <= 1'b0;
      rd_ptr_reg   <= 1'b0;
      count_reg    <= 2'h0;
      sample_ready <= 1'b0;
    end else begin
      if (push) begin
        buf_mem[wr_ptr_reg] <= {sample_left, sample_right};
        wr_ptr_reg          <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg    <= count_next;
      sample_ready <= (count_next != 2'(BUF_DEPTH));
    end
  end

  // ***************************************************
  // Serial output shifter
  // ***************************************************
  logic [W-1:0] width_mask;
  logic [W-1:0] right_hold_reg;
  logic [W-1:0] load_word;
  logic [W-1:0] shift_reg;

  assign width_mask = (word_width_sel == WIDTH_16) ? MASK_16 :
                      (word_width_sel == WIDTH_20) ? MASK_20 :
                      MASK_24;
  assign load_word = !src_fclk ?
                     (pop ? buf_head[2*W-1:W] : '0) :
                     right_hold_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      right_hold_reg <= '0;
      shift_reg      <= '0;
      adc_serial_out <= 1'b0;
    end else begin
      if (frame_edge && !src_fclk) begin
        right_hold_reg <= pop ? buf_head[W-1:0] : '0;
      end
      if (frame_edge) begin
        // Gap bit at the frame edge, MSB one bit clock later
        shift_reg      <= load_word & width_mask;
        adc_serial_out <= 1'b0;
      end else if (bclk_fall) begin
        adc_serial_out <= shift_reg[W-1];
        shift_reg      <= {shift_reg[W-2:0], 1'b0};
      end
    end
  end

  // ***************************************************
  // Peak detectors
  // ***************************************************
  // Read strobes come from the peak_read_left and peak_read_right inputs
  aps_peak_detect #(.W(W)) u_peak_left (
    .clock        (clock),
    .rst          (rst),
    .sample       (buf_head[2*W-1:W]),
    .sample_valid (pop),
    .peak_read    (peak_read_left),
    .peak         (peak_left)
  );

  aps_peak_detect #(.W(W)) u_peak_right (
    .clock        (clock),
    .rst          (rst),
    .sample       (buf_head[W-1:0]),
    .sample_valid (pop),
    .peak_read    (peak_read_right),
    .peak         (peak_right)
  );
endmodule

// file: dv/aps_adc_port_asserts.sv
// Checker for the ADC port clocking, strap and peak outputs
`timescale 1ns/1ns
module aps_adc_port_chk
  import aps_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst,
  input wire logic              ms_strap_pin,
  input wire logic              rate_fast_sel,
  input wire logic              peak_read_left,
  input wire logic              peak_read_right,
  input wire logic [PEAK_W-1:0] peak_left,
  input wire logic [PEAK_W-1:0] peak_right,
  input wire logic              adc_bit_clock_out,
  input wire logic              adc_bit_clock_oe,
  input wire logic              adc_frame_clock_out,
  input wire logic              adc_frame_clock_oe,
  input wire logic [7:0]        decim_ratio,
  input wire logic              master_mode
);
  // ****************************************
  // Frame half-length counter
  // ****************************************
  logic [8:0] hcnt_reg;
  logic       seen_reg;
  logic       fr_reg;
  logic       live_reg;
  wire        fchg = adc_frame_clock_out != fr_reg;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      {hcnt_reg, seen_reg, fr_reg, live_reg} <= '0;
    end else begin
      live_reg <= 1'b1;
      hcnt_reg <= fchg ? 9'h000 : hcnt_reg + 9'h001;
      seen_reg <= seen_reg | fchg;
      fr_reg   <= adc_frame_clock_out;
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst || !live_reg);
  a_decim_fast: assert property (rate_fast_sel
    |=> decim_ratio == OSR_FAST)
    else $error("decim ratio not 64 in fast rate");
  a_decim_slow: assert property (!rate_fast_sel
    |=> decim_ratio == OSR_SLOW)
    else $error("decim ratio not 128 in slow rate");
  a_oe_master: assert property ($stable(ms_strap_pin)[*5]
    |-> adc_bit_clock_oe == !ms_strap_pin
    && adc_frame_clock_oe == !ms_strap_pin)
    else $error("clock pin enables disagree with strap");
  a_strap_mode: assert property ($stable(ms_strap_pin)[*5]
    |-> master_mode == !ms_strap_pin)
    else $error("mode does not follow strap");
  a_slave_quiet: assert property (ms_strap_pin[*4]
    |-> !adc_bit_clock_out && !adc_frame_clock_out && !adc_bit_clock_oe)
    else $error("clock pins driven in slave mode");
  a_bclk_slow: assert property (
    $rose(adc_bit_clock_out) && !rate_fast_sel
    |-> adc_bit_clock_out[*4] ##1 !adc_bit_clock_out)
    else $error("slow bit clock period wrong");
  a_bclk_fast: assert property (
    $rose(adc_bit_clock_out) && rate_fast_sel
    |-> adc_bit_clock_out[*2] ##1 !adc_bit_clock_out)
    else $error("fast bit clock period wrong");
  a_frame_half: assert property (
    seen_reg && fchg && master_mode
    |-> hcnt_reg == (rate_fast_sel ? 9'h07F : 9'h0FF))
    else $error("frame half length wrong");
  a_peak_left: assert property (!peak_read_left
    |=> peak_left <= $past(peak_left))
    else $error("left peak rose without read");
  a_peak_right: assert property (!peak_read_right
    |=> peak_right <= $past(peak_right))
    else $error("right peak rose without read");
endmodule
bind aps_adc_port aps_adc_port_chk aps_adc_port_chk_i (.clock, .rst,
  .ms_strap_pin, .rate_fast_sel, .peak_read_left, .peak_read_right,
  .peak_left, .peak_right, .adc_bit_clock_out, .adc_bit_clock_oe,
  .adc_frame_clock_out, .adc_frame_clock_oe, .decim_ratio, .master_mode);

// file: dv/aps_ctrl_model.sv
// Audio controller model: slave clocks and serial word capture
`timescale 1ns/1ns
module aps_ctrl_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        drive_en,
  input  wire logic        bclk,
  input  wire logic        frame,
  input  wire logic        sdata,
  output logic             bclk_drv,
  output logic             frame_drv,
  output logic      [23:0] word_l,
  output logic      [23:0] word_r,
  output logic             got
);
  // ****************************************
  // Clock generation and capture
  // ****************************************
  logic [8:0]  gen_reg;
  logic [23:0] sh_reg;
  logic [5:0]  n_reg;
  logic        bq_reg, fr_reg, cur_reg;
  wire  [23:0] nxt = {sh_reg[22:0], sdata};
  assign bclk_drv  = drive_en & gen_reg[2];
  assign frame_drv = drive_en & gen_reg[8];
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      {gen_reg, sh_reg, n_reg, bq_reg, fr_reg, cur_reg, got} <= '0;
      {word_l, word_r} <= '0;
    end else begin
      gen_reg <= drive_en ? gen_reg + 9'h001 : 9'h000;
      bq_reg  <= bclk;
      got     <= 1'b0;
      if (!bq_reg && bclk) fr_reg <= frame;
      if (bq_reg && !bclk) begin
        if (fr_reg != cur_reg) begin
          cur_reg <= fr_reg;
          n_reg   <= 6'h02;
        end else begin
          n_reg <= n_reg + 6'h01;
          if (n_reg >= 6'h02 && n_reg <= 6'h19) sh_reg <= nxt;
          if (n_reg == 6'h19 && !cur_reg) word_l <= nxt;
          if (n_reg == 6'h19 && cur_reg) begin
            word_r <= nxt;
            got    <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// file: dv/aps_adc_port_bench.sv
// Testbench for the ADC port block
`timescale 1ns/1ns
module aps_adc_port_bench import aps_pkg::*;;
  // ****************************************
  // Signals, model and design
  // ****************************************
  logic        clock, rst, strap, rate, sv, rdl, rdr;
  logic [1:0]  wsel;
  logic [23:0] sl, sr, wl, wr;
  logic [5:0]  pkl, pkr, pel, per;
  logic [7:0]  dr;
  logic        sready, bo, boe, fo, foe, so, mm, pb, pf, got;
  logic [47:0] exp_q[$];
  int          mismatches, n_checks, md;
  wire         bw = boe ? bo : pb;
  wire         fw = foe ? fo : pf;
  aps_adc_port aps_adc_port_i (.clock, .rst, .ms_strap_pin(strap),
    .adc_bit_clock_in(bw), .adc_frame_clock_in(fw), .rate_fast_sel(rate),
    .word_width_sel(wsel), .sample_left(sl), .sample_right(sr),
    .sample_valid(sv), .sample_ready(sready), .peak_read_left(rdl),
    .peak_read_right(rdr), .peak_left(pkl), .peak_right(pkr),
    .adc_bit_clock_out(bo), .adc_bit_clock_oe(boe),
    .adc_frame_clock_out(fo), .adc_frame_clock_oe(foe),
    .adc_serial_out(so), .decim_ratio(dr), .master_mode(mm));
  aps_ctrl_model aps_ctrl_model_i (.clock, .rst, .drive_en(strap),
    .bclk(bw), .frame(fw), .sdata(so), .bclk_drv(pb), .frame_drv(pf),
    .word_l(wl), .word_r(wr), .got);
  // ****************************************
  // Expectations and tasks
  // ****************************************
  function automatic logic [23:0] msk(logic [23:0] s);
    return s & (wsel == WIDTH_16 ? MASK_16 :
                wsel == WIDTH_20 ? MASK_20 : MASK_24);
  endfunction
  function automatic logic [5:0] code(logic [23:0] s);
    logic [23:0] m;
    int          p;
    int          t[8] = '{0, 1, 2, 3, 4, 4, 5, 5};
    m = s[23] ? -s : s;
    p = 23;
    if (m == 24'h000000) return 6'h3F;
    while (!m[p]) p--;
    m = m << (23 - p);
    p = 6 * (23 - p) - t[m[22:20]];
    return (p < 0) ? 6'h00 : (p > 63) ? 6'h3F : 6'(p);
  endfunction
  function automatic logic [23:0] rnd();
    return 24'($urandom) | 24'h000100;
  endfunction
  task automatic wrap_up;
    if (mismatches == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(logic [23:0] a, logic [23:0] e);
    n_checks++;
    if (a !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, a, e);
    end
  endtask
  task automatic push(logic [23:0] l, logic [23:0] r);
    int i;
    sl <= l;
    sr <= r;
    sv <= 1'b1;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (sready !== 1'b1 && i < 3000);
    if (sready !== 1'b1) begin
      mismatches++;
      wrap_up;
    end
    exp_q.push_back({l, r});
  endtask
  task automatic drain;
    int i;
    sv <= 1'b0;
    for (i = 0; i < 3000 && exp_q.size() > 0; i++) @(posedge clock);
    if (exp_q.size() > 0) begin
      mismatches++;
      wrap_up;
    end
    @(posedge clock);
  endtask
  task automatic rd_pk;
    rdl <= 1'b1;
    rdr <= 1'b1;
    @(posedge clock);
    chk(24'(pkl), 24'(pel));
    chk(24'(pkr), 24'(per));
    rdl <= 1'b0;
    rdr <= 1'b0;
    @(posedge clock);
    chk(24'(pkl), 24'h3F);
    chk(24'(pkr), 24'h3F);
    pel = 6'h3F;
    per = 6'h3F;
  endtask
  always @(posedge clock) begin
    if (got === 1'b1 && {wl, wr} !== 48'h0) begin
      if (exp_q.size() == 0) exp_q.push_back(48'h0);
      chk(wl, msk(exp_q[0][47:24]));
      chk(wr, msk(exp_q[0][23:0]));
      if (code(exp_q[0][47:24]) < pel) pel = code(exp_q[0][47:24]);
      if (code(exp_q[0][23:0]) < per) per = code(exp_q[0][23:0]);
      void'(exp_q.pop_front());
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    {strap, rate, sv, rdl, rdr, wsel, sl, sr} = '0;
    rst = 1'b1;
    mismatches = 0;
    n_checks = 0;
    void'($urandom(91801));
    for (md = 0; md < 4; md++) begin
      @(posedge clock);
      rst   <= 1'b1;
      strap <= (md == 3);
      rate  <= md[0];
      wsel  <= md[1:0];
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      pel = 6'h3F;
      per = 6'h3F;
      repeat (1100) @(posedge clock);
      chk(24'(dr), rate ? 24'h40 : 24'h80);
      chk(24'(mm), 24'(!strap));
      chk(24'(boe & foe), 24'(!strap));
      push(24'h800000, 24'h7FFFFF);
      drain;
      rd_pk;
      push(rnd(), rnd());
      push(rnd(), rnd());
      sv <= 1'b0;
      repeat (2) @(posedge clock);
      chk(24'(sready), 24'h0);
      push(24'h000001, 24'hFFFFFF);
      drain;
      chk(24'(pkl), 24'(pel));
      chk(24'(pkr), 24'(per));
      repeat (3) begin
        push(rnd(), rnd());
        drain;
        if ($urandom % 2) rd_pk;
      end
    end
    wrap_up;
  end
endmodule
